// ===== bench/scan_ctrl.sv
// Scan controller model: one scan clock of 800 ns per call of step.
// Assumes it is called at a falling system clock edge; scan clock rests low between calls.
module scan_ctrl (
    // Pacing clock
    input wire logic i_clk,
    // Scan pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end
    // Data out is read just before the fall, well after the previous fall launched it
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        o_tms = tms;
        o_tdi = tdi;
        repeat (4) @(negedge i_clk);
        o_tck = 1'b1;
        repeat (4) @(negedge i_clk);
        tdo = i_tdo;
        o_tck = 1'b0;
    endtask
endmodule

// ===== bench/sram_boundary_scan_tap_tb.sv
// Testbench: identification read, every instruction code, reset by mode-select.
// Assumes the scan controller model paces the scan pins from the system clock.
module sram_boundary_scan_tap_tb
    import tap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [ID_MFR_W-1:0] MFR = 11'h35a; // Arbitrary value
    localparam logic [ID_W-1:0] ID_EXP = {20'h0_0000, MFR, ID_PRESENCE};
    localparam logic [19:0] DIN = 20'h5_3c96;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, extest, off;
    logic [11:0] pads = 12'ha5c;
    logic [11:0] pin_out;
    int err_count = 0;
    int check_count = 0;
    `define CHK(name, exp, got) begin check_count++; if ((got) !== (exp)) begin err_count++; \
        $display("ERROR %s expected %h seen %h", name, exp, got); end end
    always #50 i_clk = ~i_clk;
    scan_ctrl scan_ctrl_inst (.i_clk(i_clk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo));
    sram_boundary_scan_tap #(.MFR_CODE(MFR)) sram_boundary_scan_tap_inst (.i_clk(i_clk), .i_rst(i_rst),
        .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_pins(pads),
        .o_pin_out(pin_out), .o_extest(extest), .o_outputs_off(off));
    task automatic moves(input logic [7:0] seq, input int n);
        logic t;
        for (int i = 0; i < n; i++)
            scan_ctrl_inst.step(seq[i], 1'b1, t);
    endtask
    // Shift n bits from a shift state, then through update to idle
    task automatic shift(input int n, input logic [39:0] din, output logic [39:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++)
            scan_ctrl_inst.step(i == n - 1, din[i], dout[i]);
        moves(8'h01, 2);
    endtask
    task automatic read_id();
        logic [39:0] d;
        moves(8'h02, 4);
        repeat (8) @(negedge i_clk);
        `CHK("oe in shift", 1'b1, tdo_oe)
        shift(32, 40'h0, d);
        `CHK("id word", ID_EXP, d[31:0])
        `CHK("oe in idle", 1'b0, tdo_oe)
    endtask
    task automatic load_ir(input logic [2:0] code);
        logic [39:0] d;
        moves(8'h03, 4);
        shift(3, {37'h0, code}, d);
        `CHK("ir capture", 2'b01, d[1:0])
    endtask
    task automatic each_code();
        logic [39:0] d;
        logic [19:0] exp;
        for (int c = 0; c < 8; c++) begin
            pads = 12'ha5c ^ {4{c[2:0]}};
            load_ir(c[2:0]);
            repeat (8) @(negedge i_clk);
            `CHK("extest mode", c == 0, extest)
            `CHK("float mode", c == 2, off)
            moves(8'h01, 3);
            shift(20, {20'h0_0000, DIN}, d);
            exp = c == 1 ? ID_EXP[19:0] : (c % 2 == 0 && c != 6) ? {DIN[3:0], 4'hf, pads} : {DIN[18:0], 1'b0};
            `CHK("data path", exp, d[19:0])
            if (c % 2 == 0 && c != 6)
                `CHK("pad latch", DIN[15:4], pin_out)
        end
    endtask
    // Five high edges from inside a data shift must drop any loaded mode
    task automatic tms_reset();
        load_ir(3'h0);
        moves(8'h01, 3);
        moves(8'h1f, 5);
        repeat (8) @(negedge i_clk);
        `CHK("mode after reset", 1'b0, extest)
        read_id();
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_clk);
        `CHK("oe after reset", 1'b0, tdo_oe)
        moves(8'h3f, 6);
        read_id();
        each_code();
        tms_reset();
        final_report();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        final_report();
    end
endmodule

// ===== bench/tap_sva.sv
// Checker: scan port outputs timed against the raw scan pins.
// Assumes scan clock half periods of at least four system clocks.
module tap_sva #(
    parameter int PINS = 12
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Scan pins
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    // Pad ring
    input wire logic [PINS-1:0] o_pin_out,
    input wire logic o_extest,
    input wire logic o_outputs_off
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic tck_d;
    logic rise;
    logic [3:0] still;
    logic [2:0] highs;
    assign rise = i_tck && !tck_d;
    // Counters see the raw pins, so thresholds leave room for the synchroniser delay
    always_ff @(posedge i_clk) begin
        tck_d <= i_tck;
        still <= (i_rst || i_tck != tck_d) ? 4'h0 : still + {3'h0, still != 4'hf};
        highs <= (i_rst || (rise && !i_tms)) ? 3'h0 : highs + {2'h0, rise && highs != 3'h7};
    end
    a_reset_idle: assert property (disable iff (1'b0) i_rst |=> !o_tdo_oe && !o_extest && !o_outputs_off)
        else $error("Outputs active after reset");
    a_tdo_on_fall: assert property ($changed(o_tdo) && !$past(i_rst) |-> !$past(i_tck, 3))
        else $error("Data out moved away from a scan clock fall");
    a_oe_on_fall: assert property ($changed(o_tdo_oe) && !$past(i_rst) |-> !$past(i_tck, 3))
        else $error("Data out enable moved away from a fall");
    a_pads_on_fall: assert property ($changed(o_pin_out) && !$past(i_rst) |-> !$past(i_tck, 3))
        else $error("Pad latch moved away from a fall");
    a_mode_on_rise: assert property ($changed(o_extest) && !$past(i_rst) |-> $past(i_tck, 3) || $past(i_tck, 4))
        else $error("Mode moved away from a scan clock rise");
    a_one_mode: assert property (!(o_extest && o_outputs_off))
        else $error("Two modes active");
    a_idle_still: assert property (still >= 4'hc |-> $stable(o_tdo) && $stable(o_tdo_oe) && $stable(o_extest))
        else $error("Outputs moved with the scan clock at rest");
    a_five_high: assert property (highs >= 3'h6 |-> !o_extest && !o_outputs_off)
        else $error("Mode kept after five high mode-select edges");
    c_shift: cover property ($rose(o_tdo_oe));
    c_extest: cover property ($rose(o_extest));
    c_float: cover property ($rose(o_outputs_off));
endmodule
bind sram_boundary_scan_tap tap_sva #(.PINS(PINS)) tap_sva_inst (.i_clk(i_clk), .i_rst(i_rst), .i_tck(i_tck),
    .i_tms(i_tms), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_pin_out(o_pin_out), .o_extest(o_extest),
    .o_outputs_off(o_outputs_off));

// ===== include/tap_pkg.sv
// Package for the boundary-scan test port: TAP states, instruction codes, widths.
// Assumes a single system clock that oversamples the scan clock pin.
package tap_pkg;

    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W_DEF = 16;
    localparam int SYNC_STAGES = 3;
    localparam int RESET_TMS_EDGES = 5;

    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLEZ = 3'h2;
    localparam logic [IR_W-1:0] INS_RFU3 = 3'h3;
    localparam logic [IR_W-1:0] INS_PRELOAD = 3'h4;
    localparam logic [IR_W-1:0] INS_RFU6 = 3'h6;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
    localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;
    localparam logic [1:0] IR_CAPTURE = 2'h1;

    localparam int ID_PRESENCE_BIT = 0;
    localparam int ID_MFR_LSB = 1;
    localparam int ID_MFR_W = 11;
    localparam logic ID_PRESENCE = 1'b1;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } tap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } scan_pins_t;

endpackage

// ===== verilog/pin_sync.sv
// Three-stage synchroniser for the scan pins, with agreement filter.
// Assumes pins are asynchronous to i_clk; output changes only when stages two and three agree.
module pin_sync
    import tap_pkg::*;
#(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_level
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            wire agree = (s2[g] == s3[g]);
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    s1[g] <= INIT[g];
                    s2[g] <= INIT[g];
                    s3[g] <= INIT[g];
                    o_level[g] <= INIT[g];
                end else begin
                    s1[g] <= i_async[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (agree) begin
                        o_level[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate
endmodule

// ===== verilog/sram_boundary_scan_tap.sv
// Boundary-scan test access port of a synchronous memory, run on the system clock.
// Assumes scan pins arrive asynchronously; pad levels come in on i_pins, drivers go out on o_pin_out.
module sram_boundary_scan_tap
    import tap_pkg::*;
#(
    parameter int BSR_W = BSR_W_DEF,
    parameter int PINS = 12,
    parameter logic [ID_MFR_W-1:0] MFR_CODE = 11'h0_2a5,  // Arbitrary value
    parameter logic [ID_W-ID_MFR_W-1-1:0] ID_UPPER = 20'h0_0000
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Scan pins; a floating pin shows as one through its pull-up
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe,
    // Memory pad ring
    input wire logic [PINS-1:0] i_pins,
    output logic [PINS-1:0] o_pin_out,
    output logic o_extest,
    output logic o_outputs_off
);
    scan_pins_t raw;
    scan_pins_t pins;
    logic tck_q;
    tap_state_t state;
    tap_state_t next_state;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir;
    logic bypass;
    logic [ID_W-1:0] id_reg;
    logic [BSR_W-1:0] bsr;
    logic [BSR_W-1:0] bsr_upd;
    logic [2:0] tms_ones;

    assign raw = '{tck: i_tck, tms: i_tms, tdi: i_tdi};

    // Reset value of one matches the pull-ups, so an unused port sits in reset
    pin_sync #(
        .WIDTH(3),
        .INIT(3'h7)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_async(raw),
        .o_level(pins)
    );

    wire tck_rise = pins.tck & ~tck_q;
    wire tck_fall = ~pins.tck & tck_q;
    wire tms = pins.tms;
    wire tdi = pins.tdi;

    // unused codes 011, 110 and the private 101 fall to bypass
    wire sel_bsr = (ir == INS_EXTEST) || (ir == INS_SAMPLEZ) || (ir == INS_PRELOAD);
    wire sel_id = (ir == INS_IDCODE);
    wire sel_byp = ~sel_bsr & ~sel_id;
    wire in_shift_dr = (state == ST_SHIFT_DR);
    wire in_shift_ir = (state == ST_SHIFT_IR);
    wire [ID_W-1:0] id_rom = {ID_UPPER, MFR_CODE, ID_PRESENCE};
    wire [BSR_W-1:0] bsr_cap = {{(BSR_W-PINS){1'b1}}, i_pins};
    wire dr_out = sel_bsr ? bsr[0] : (sel_id ? id_reg[0] : bypass);
    wire serial_out = in_shift_ir ? ir_shift[0] : dr_out;

    always_comb begin
        case (state)
            ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
            default: next_state = ST_RESET;
        endcase
    end

    // Controller advances on sampled rises only; no edges means the port stays put
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tck_q <= 1'b1;
            state <= ST_RESET;
        end else begin
            tck_q <= pins.tck;
            if (tck_rise) begin
                state <= next_state;
            end
        end
    end

    // Counter of consecutive high mode-select rises; the fifth forces the instruction register to its reset code from any state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tms_ones <= 3'h0;
        end else if (tck_rise) begin
            tms_ones <= tms ? ((tms_ones == 3'(RESET_TMS_EDGES)) ? tms_ones : tms_ones + 3'h1) : 3'h0;
        end
    end
    // The state graph already reaches reset within five high edges; the counter is a backstop
    wire force_reset = tck_rise && tms && (tms_ones >= 3'(RESET_TMS_EDGES - 1));

    // Instruction register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ir_shift <= IR_RESET;
            ir <= IR_RESET;
        end else if (force_reset || (state == ST_RESET)) begin
            ir <= IR_RESET;
        end else if (tck_rise) begin
            case (state)
                ST_CAP_IR: ir_shift <= {ir_shift[IR_W-1:2], IR_CAPTURE};
                ST_SHIFT_IR: ir_shift <= {tdi, ir_shift[IR_W-1:1]};
                ST_UPD_IR: ir <= ir_shift;
                default: ir <= ir;
            endcase
        end
    end

    // Data registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bypass <= 1'b0;
            id_reg <= '0;
            bsr <= '1;
        end else if (tck_rise) begin
            if (state == ST_CAP_DR) begin
                bypass <= 1'b0;
                if (sel_id) begin
                    id_reg <= id_rom;
                end
                if (sel_bsr) begin
                    bsr <= bsr_cap;
                end
            end else if (in_shift_dr) begin
                if (sel_byp) begin
                    bypass <= tdi;
                end
                if (sel_id) begin
                    id_reg <= {tdi, id_reg[ID_W-1:1]};
                end
                if (sel_bsr) begin
                    bsr <= {tdi, bsr[BSR_W-1:1]};
                end
            end
        end
    end

    // Update latch drives the pads under extest; taken on the falling edge of the data update state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bsr_upd <= '0;
        end else if (tck_fall && sel_bsr && (state == ST_UPD_DR)) begin
            bsr_upd <= bsr;
        end
    end

    // Serial output launched on the falling edge, enabled only in shift states
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            o_tdo <= serial_out;
            o_tdo_oe <= in_shift_dr | in_shift_ir;
        end
    end

    // Memory output control follows the active instruction
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_extest <= 1'b0;
            o_outputs_off <= 1'b0;
            o_pin_out <= '0;
        end else begin
            o_extest <= (ir == INS_EXTEST);
            o_outputs_off <= (ir == INS_SAMPLEZ);
            o_pin_out <= bsr_upd[PINS-1:0];
        end
    end
endmodule
